//--- logic/swdd_ctrl.sv
`timescale 1ns/10ps
module swdd_ctrl import swdd_pkg::*; #(
	parameter int TICK = TICK_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [NCH-1:0] ind_in,
	input wire logic [3*NB-1:0] board_type,
	output logic [NCH-1:0] drive_out,
	output logic [NCH-1:0] led_out,
	output logic [4*NB-1:0] led_current_level,
	output logic [NB-1:0] bank_output_stage,
	output logic [1:0] drive_supply_select,
	output logic busy
);
	typedef struct packed {
		logic [NCH-1:0][31:0] cfg;
		logic [NB-1:0][7:0] bank;
		logic [1:0] supply;
		logic [1:0] boot;
		logic [3:0] limit;
		logic refused;
		logic busy;
		swdd_seq_t st;
		logic [6:0] ch;
		logic [7:0] ms;
		logic [16:0] pre;
		logic [NCH-1:0] drive;
		logic [NCH-1:0] led;
		logic aw_got;
		logic w_got;
		logic [11:0] wa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic awrdy;
		logic wrdy;
		logic arrdy;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
	} swdd_state_t;

	swdd_state_t q;
	swdd_state_t d;
	logic wr_fire;
	logic cmd_factory;
	logic cmd_slot;
	logic cmd_preset;
	logic [1:0] cmd_bank;
	logic tick;
	logic [31:0] wmask;
	logic [31:0] cur;
	logic [2:0] preset_type;
	logic [31:0] preset_word;
	logic [NCH-1:0] pulsed_mask;

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d = q;
		wmask = {{8{q.ws[3]}}, {8{q.ws[2]}}, {8{q.ws[1]}}, {8{q.ws[0]}}};
		wr_fire = q.aw_got && q.w_got && !q.bv;
		cmd_factory = wr_fire && q.wa == A_CMD && q.wd[K_FACTORY];
		cmd_slot = wr_fire && q.wa == A_CMD && q.wd[K_SLOT];
		cmd_preset = wr_fire && q.wa == A_CMD && q.wd[K_PRESET];
		cmd_bank = q.wd[K_BANK +: 2];
		tick = q.pre == 17'(TICK - 1);
		cur = q.cfg[q.ch];
		preset_type = board_type[3 * cmd_bank +: 3];
		preset_word = CH_FACTORY;
		for (int i = 0; i < NCH; i++)
			pulsed_mask[i] = q.cfg[i][C_PULSED];
		// Millisecond prescaler
		d.pre = tick ? 17'h0 : q.pre + 17'h1;
		// Write channels
		if (awvalid && q.awrdy) begin
			d.aw_got = 1'b1;
			d.wa = awaddr[11:0];
		end
		if (wvalid && q.wrdy) begin
			d.w_got = 1'b1;
			d.wd = wdata;
			d.ws = wstrb;
		end
		if (q.bv && bready)
			d.bv = 1'b0;
		if (wr_fire) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bv = 1'b1;
			d.br = RESP_OK;
			if (q.wa == A_CTRL) begin
				if (q.ws[0]) begin
					d.supply = q.wd[1:0];
					d.boot = q.wd[3:2];
					d.limit = q.wd[7:4];
				end
			end else if (q.wa == A_STAT) begin
				if (q.ws[0] && q.wd[1])
					d.refused = 1'b0;
			end else if (q.wa == A_CMD || q.wa == A_BOARD) begin
				d.br = RESP_OK;
			end else if (q.wa >= A_BANK && q.wa < A_CHAN && q.wa[11:4] == 8'h01
				&& q.wa[1:0] == 2'h0) begin
				if (q.ws[0])
					d.bank[q.wa[3:2]] = q.wd[7:0];
			end else if (q.wa >= A_CHAN && q.wa <= A_CHAN_END && q.wa[1:0] == 2'h0) begin
				d.cfg[7'((q.wa - A_CHAN) >> 2)] = (q.cfg[7'((q.wa - A_CHAN) >> 2)] & ~wmask)
					| (q.wd & wmask);
			end else begin
				d.br = RESP_ERR;
			end
		end
		// Factory values for the whole slot, no board detection
		if (cmd_factory) begin
			d.supply = SUP_OFF;
			d.boot = SUP_OFF;
			d.limit = LIMIT_FACTORY;
			for (int b = 0; b < NB; b++)
				d.bank[b] = BANK_FACTORY;
			for (int i = 0; i < NCH; i++)
				d.cfg[i] = CH_FACTORY;
		end
		// Board-type preset of one bank
		if (cmd_preset) begin
			if (q.supply != SUP_OFF || q.busy) begin
				d.refused = 1'b1;
			end else begin
				d.bank[cmd_bank] = BANK_FACTORY;
				for (int j = 0; j < NCPB; j++) begin
					preset_word = CH_FACTORY;
					preset_word[C_PAIR] = preset_type == 3'h1 || preset_type == 3'h3
						|| preset_type == 3'h4 || preset_type == 3'h5;
					preset_word[C_INV] = preset_type == 3'h3 || preset_type == 3'h4;
					preset_word[C_CLOSED] = preset_type == 3'h3 || (preset_type == 3'h2
						&& (j + 1 == PAIR_CH_A || j + 1 == PAIR_CH_B));
					d.cfg[NCPB * cmd_bank + j] = preset_word;
				end
			end
		end
		// Slot reset: reload boot drive state and restore defaults
		if (cmd_slot && !q.busy) begin
			d.supply = q.boot;
			d.busy = 1'b1;
			d.ch = 7'h0;
			d.st = SQ_IDLE;
		end
		// Default restoration, one channel at a time
		case (q.st)
			SQ_IDLE: begin
				if (q.busy && !cmd_slot) begin
					if (q.supply != SUP_OFF
						&& !(cur[C_PULSED] && !cur[C_PAIR] && !cur[C_CLOSED])) begin
						d.drive[q.ch] = cur[C_CLOSED] || cur[C_PAIR];
						d.ms = cur[C_WIDTH +: 8];
						d.pre = 17'h0;
						d.st = SQ_PULSE;
					end else if (q.ch == 7'(NCH - 1)) begin
						d.busy = 1'b0;
					end else begin
						d.ch = q.ch + 7'h1;
					end
				end
			end
			SQ_PULSE: begin
				if (q.ms == 8'h0) begin
					d.drive[q.ch] = !cur[C_PULSED] && cur[C_CLOSED];
					d.ms = cur[C_SETTLE +: 8];
					d.pre = 17'h0;
					d.st = SQ_SETTLE;
				end else if (tick) begin
					d.ms = q.ms - 8'h1;
				end
			end
			SQ_SETTLE: begin
				if (q.ms == 8'h0) begin
					d.ms = cur[C_RECOV +: 8];
					d.pre = 17'h0;
					d.st = SQ_RECOV;
				end else if (tick) begin
					d.ms = q.ms - 8'h1;
				end
			end
			SQ_RECOV: begin
				if (q.ms == 8'h0) begin
					d.st = SQ_IDLE;
					if (q.ch == 7'(NCH - 1))
						d.busy = 1'b0;
					else
						d.ch = q.ch + 7'h1;
				end else if (tick) begin
					d.ms = q.ms - 8'h1;
				end
			end
			default: d.st = SQ_IDLE;
		endcase
		// Drive supply switched off ends all drive
		if (d.supply == SUP_OFF)
			d.drive = '0;
		// LED lines
		for (int i = 0; i < NCH; i++)
			d.led[i] = q.supply != SUP_OFF && q.bank[i / NCPB][B_LEDON]
				&& (ind_in[i] ^ q.cfg[i][C_INV]);
		d.awrdy = !d.aw_got && !d.bv;
		d.wrdy = !d.w_got && !d.bv;
		// Read channel
		if (q.rv && rready)
			d.rv = 1'b0;
		if (arvalid && q.arrdy) begin
			d.rv = 1'b1;
			d.rr = RESP_OK;
			d.rd = 32'h0;
			if (araddr[11:0] == A_CTRL)
				d.rd = {24'h0, q.limit, q.boot, q.supply};
			else if (araddr[11:0] == A_STAT)
				d.rd = {23'h0, q.ch, q.refused, q.busy};
			else if (araddr[11:0] == A_CMD)
				d.rd = 32'h0;
			else if (araddr[11:0] == A_BOARD)
				d.rd = 32'(board_type);
			else if (araddr[11:4] == 8'h01 && araddr[1:0] == 2'h0)
				d.rd = {24'h0, q.bank[araddr[3:2]]};
			else if (araddr[11:0] >= A_CHAN && araddr[11:0] <= A_CHAN_END
				&& araddr[1:0] == 2'h0)
				d.rd = q.cfg[7'((araddr[11:0] - A_CHAN) >> 2)];
			else
				d.rr = RESP_ERR;
		end
		d.arrdy = !d.rv;
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			for (int i = 0; i < NCH; i++)
				q.cfg[i] <= CH_FACTORY;
			for (int b = 0; b < NB; b++)
				q.bank[b] <= BANK_FACTORY;
			q.limit <= LIMIT_FACTORY;
			q.busy <= 1'b1;
			q.st <= SQ_IDLE;
		end else begin
			q <= d;
		end
	end

	always_comb begin
		awready = q.awrdy;
		wready = q.wrdy;
		bvalid = q.bv;
		bresp = q.br;
		arready = q.arrdy;
		rvalid = q.rv;
		rdata = q.rd;
		rresp = q.rr;
		drive_out = q.drive;
		led_out = q.led;
		drive_supply_select = q.supply;
		busy = q.busy;
		for (int b = 0; b < NB; b++) begin
			led_current_level[4 * b +: 4] = q.bank[b][B_LEVEL +: 4];
			bank_output_stage[b] = q.bank[b][B_STAGE];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_led_gated: assert property (led_out != '0 |-> $past(q.supply) != SUP_OFF)
		else $error("LED driven while supply off");
	chk_led_follow: assert property ((q.supply != SUP_OFF && q.bank[0][B_LEDON]) |=>
		led_out[0] == $past(ind_in[0] ^ q.cfg[0][C_INV]))
		else $error("LED does not follow indicator");
	chk_preset_refuse: assert property ((cmd_preset && q.supply != SUP_OFF) |=>
		q.refused && $stable(q.cfg))
		else $error("Preset accepted with supply on");
	chk_factory_vals: assert property (cmd_factory |=>
		q.supply == SUP_OFF && q.boot == SUP_OFF && q.limit == LIMIT_FACTORY
		&& q.bank[0] == BANK_FACTORY)
		else $error("Factory module values wrong");
	chk_factory_chan: assert property (cmd_factory |=> q.cfg[NCH-1] == CH_FACTORY)
		else $error("Factory channel values wrong");
	chk_skip_open: assert property (q.st == SQ_PULSE |->
		!(cur[C_PULSED] && !cur[C_PAIR] && !cur[C_CLOSED]))
		else $error("Drive on single pulsed open channel");
	chk_one_drive: assert property (q.st != SQ_IDLE |-> $onehot0(drive_out & pulsed_mask))
		else $error("More than one channel driven");
	chk_recov_quiet: assert property (q.st == SQ_RECOV && cur[C_PULSED] |->
		!drive_out[q.ch])
		else $error("Drive during recovery");
	chk_tick_period: assert property (tick |=> q.pre == 17'h0)
		else $error("Prescaler period wrong");
	chk_pre_step: assert property ((q.st == SQ_PULSE && q.ms != 8'h0 && !tick) |=>
		q.pre == $past(q.pre) + 17'h1)
		else $error("Prescaler did not advance");
	chk_preset_type3: assert property ((cmd_preset && cmd_bank == 2'h1
		&& board_type[5:3] == 3'h3 && q.supply == SUP_OFF && !q.busy) |=>
		q.cfg[NCPB][C_CLOSED] && q.cfg[NCPB][C_PAIR] && q.cfg[NCPB][C_INV]
		&& q.cfg[NCPB][C_WIDTH +: 8] == 8'(PULSE_MS))
		else $error("Preset values wrong");
	chk_write_resp: assert property ((q.aw_got && q.w_got && !q.bv) |=> bvalid)
		else $error("Write not answered");
	chk_read_resp: assert property ((arvalid && arready) |=> rvalid)
		else $error("Read not answered");
	chk_drive_gated: assert property (drive_supply_select == SUP_OFF |-> drive_out == '0)
		else $error("Drive while supply off");
	chk_ready_reset: assert property ($rose(aresetn) |=> awready && wready && arready)
		else $error("Bus not ready after reset");
	chk_restore_start: assert property ($rose(aresetn) |-> busy && q.st == SQ_IDLE)
		else $error("Restoration not pending after reset");
	chk_slot_reload: assert property ((cmd_slot && !q.busy) |=>
		busy && drive_supply_select == $past(q.boot))
		else $error("Slot reset did not restore");

	cov_pulse: cover property (q.st == SQ_PULSE ##1 q.st == SQ_SETTLE);
	cov_refuse: cover property (cmd_preset && q.supply != SUP_OFF);
	cov_factory: cover property (cmd_factory);
	cov_restore_end: cover property ($fell(q.busy));
	cov_preset_ok: cover property (cmd_preset && q.supply == SUP_OFF && !q.busy);
endmodule // swdd_ctrl

//--- logic/swdd_pkg.sv
// Behaviour
// - LED line follows its channel position indicator
// - No LED drive while drive supply off
// - Factory reset loads module factory values, no detection
// - Factory reset loads channel factory values
// - Instrument and slot resets redetect boards; slot reset drives channel defaults, instrument reset leaves supply off and drives none
// - Each channel keeps open or closed default
// - Single pulsed default-open channels get no drive
// - Boot drive source off, internal or external
// - Slot reset reruns default restoration with supply set to boot source
// - Bank preset loads board-type dependent defaults
// - Preset pairing, polarity, default per board type
// - Bank preset refused unless drive supply off and no default restoration running
// - Up to four boards, one bank each
// - Board type per position readable by software
// - Pulse, then recovery wait before next channel
package swdd_pkg;
	localparam int NB = 4;
	localparam int NCPB = 20;
	localparam int NCH = NB * NCPB;
	localparam int CLK_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int TICK_CYCLES = MS_NS / CLK_NS;
	localparam int PULSE_MS = 15;
	localparam int LED_MA = 5;
	localparam int PAIR_CH_A = 7;
	localparam int PAIR_CH_B = 17;
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_CMD = 12'h004;
	localparam logic [11:0] A_STAT = 12'h008;
	localparam logic [11:0] A_BOARD = 12'h00C;
	localparam logic [11:0] A_BANK = 12'h010;
	localparam logic [11:0] A_CHAN = 12'h100;
	localparam logic [11:0] A_CHAN_END = 12'h23C;
	localparam int C_WIDTH = 0;
	localparam int C_RECOV = 8;
	localparam int C_SETTLE = 16;
	localparam int C_PAIR = 24;
	localparam int C_PULSED = 25;
	localparam int C_CHECK = 26;
	localparam int C_INV = 27;
	localparam int C_CLOSED = 28;
	localparam int K_FACTORY = 0;
	localparam int K_SLOT = 1;
	localparam int K_PRESET = 2;
	localparam int K_BANK = 4;
	localparam int B_STAGE = 0;
	localparam int B_LEDON = 1;
	localparam int B_LEVEL = 4;
	localparam logic [1:0] SUP_OFF = 2'h0;
	localparam logic [1:0] SUP_INT = 2'h1;
	localparam logic [1:0] SUP_EXT = 2'h2;
	localparam logic [3:0] LIMIT_FACTORY = 4'h1;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	localparam logic [31:0] CH_FACTORY = (32'h1 << C_PULSED) | 32'(PULSE_MS);
	localparam logic [7:0] BANK_FACTORY = 8'((LED_MA << B_LEVEL) | (1 << B_LEDON));
	typedef enum logic [1:0] {
		SQ_IDLE = 2'h0,
		SQ_PULSE = 2'h1,
		SQ_SETTLE = 2'h3,
		SQ_RECOV = 2'h2
	} swdd_seq_t;
endpackage

//--- tb/swdd_boards.sv
`timescale 1ns/10ps
module swdd_boards import swdd_pkg::*; (
	input wire logic aclk,
	input wire logic [NCH-1:0] drive_out,
	input wire logic [NCH-1:0] pattern,
	output logic [NCH-1:0] ind_in
);
	logic [NCH-1:0] pos_q;
	initial pos_q = '0;
	// Latching switch moves to closed once its coil is pulsed
	always @(posedge aclk) pos_q <= pos_q | drive_out;
	// Passive board: indicator line is switch position plus bench offset
	assign ind_in = pos_q ^ pattern;
endmodule // swdd_boards

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top import swdd_pkg::*;;
	localparam int T = 4;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, busy;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [1:0] bresp, rresp, supply;
	logic [NCH-1:0] ind_in, drive_out, led_out, pat;
	logic [15:0] levels;
	logic [3:0] stages;
	logic [1:0] last_bresp;
	int mismatches, comparisons, cyc;
	always #5 aclk = ~aclk;
	swdd_ctrl #(.TICK(T)) i_swdd_ctrl (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ind_in(ind_in), .board_type(12'h099), .drive_out(drive_out),
		.led_out(led_out), .led_current_level(levels), .bank_output_stage(stages),
		.drive_supply_select(supply), .busy(busy));
	swdd_boards i_swdd_boards (.aclk(aclk), .drive_out(drive_out), .pattern(pat),
		.ind_in(ind_in));
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			close_out();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= {20'h00000, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		last_bresp = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= {20'h00000, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk(n, d, e);
	endtask
	task automatic wait_idle();
		@(posedge aclk);
		while (busy) @(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		wait_idle();
		rc("ctrl", A_CTRL, 32'h00000010);
		rc("bank0", A_BANK, 32'h00000052);
		rc("ch79", A_CHAN_END, 32'h0200000F);
		chk("levels", {16'h0000, levels}, 32'h00005555);
		chk("stages", {28'h0, stages}, 32'h00000000);
		chk("led_off", led_out[31:0], 32'h00000000);
	endtask
	task automatic t_bus();
		logic [31:0] d;
		logic [1:0] r;
		axr(12'hFFC, d, r);
		chk("unmapped", {30'h0, r}, 32'h00000002);
		axw(12'hFFC, 32'h00000000);
		chk("unmapped_w", {30'h0, last_bresp}, 32'h00000002);
	endtask
	task automatic t_led();
		axw(A_BANK, 32'h00000050);
		chk("bresp_ok", {30'h0, last_bresp}, 32'h00000000);
		axw(A_BANK, 32'h00000052);
		axw(A_CTRL, 32'h00000011);
		repeat (2) @(posedge aclk);
		chk("led_b0", {12'h000, led_out[19:0]}, {12'h000, pat[19:0]});
		axw(A_CTRL, 32'h00000010);
		repeat (2) @(posedge aclk);
		chk("led_gate", {12'h000, led_out[19:0]}, 32'h00000000);
	endtask
	task automatic t_slot();
		int hi, fall, rise;
		logic other;
		hi = 0;
		fall = 0;
		rise = 0;
		other = 1'b0;
		axw(A_CHAN, 32'h12000302);
		axw(A_CHAN + 12'h008, 32'h12000001);
		axw(A_CTRL, 32'h00000014);
		axw(A_CMD, 32'h00000002);
		while (!busy) @(posedge aclk);
		while (busy) begin
			@(posedge aclk);
			hi += drive_out[0];
			if (drive_out[0]) fall = cyc;
			if (drive_out[2] && rise == 0) rise = cyc;
			other |= drive_out[1] | (|drive_out[NCH-1:3]);
		end
		chk("pulse_len", 32'(hi >= 2 * T && hi <= 2 * T + 1), 32'h1);
		chk("recovery", 32'(rise - fall > 3 * T), 32'h1);
		chk("open_quiet", {31'h0, other}, 32'h0);
		rc("boot", A_CTRL, 32'h00000015);
		chk("supply", {30'h0, supply}, 32'h00000001);
	endtask
	task automatic t_preset();
		logic [31:0] d;
		logic [1:0] r;
		rc("board", A_BOARD, 32'h00000099);
		axw(A_CMD, 32'h00000014);
		axr(A_STAT, d, r);
		chk("refused", {31'h0, d[1]}, 32'h1);
		rc("ch20_kept", 12'h150, 32'h0200000F);
		axw(A_CTRL, 32'h00000014);
		axw(A_STAT, 32'h00000002);
		axw(A_CMD, 32'h00000014);
		axw(A_CMD, 32'h00000024);
		axw(A_CMD, 32'h00000004);
		wait_idle();
		rc("ch20", 12'h150, 32'h1B00000F);
		rc("bank1", 12'h014, 32'h00000052);
		rc("ch46", 12'h1B8, 32'h1200000F);
		rc("ch40", 12'h1A0, 32'h0200000F);
		rc("ch0", A_CHAN, 32'h0300000F);
		axr(A_STAT, d, r);
		chk("accepted", {31'h0, d[1]}, 32'h0);
		axw(A_CTRL, 32'h00000015);
		repeat (2) @(posedge aclk);
		chk("led_inv", {12'h000, led_out[39:20]}, {12'h000, ~pat[39:20]});
	endtask
	task automatic t_factory();
		axw(A_CMD, 32'h00000001);
		wait_idle();
		rc("f_ctrl", A_CTRL, 32'h00000010);
		rc("f_ch20", 12'h150, 32'h0200000F);
		rc("f_bank1", 12'h014, 32'h00000052);
		chk("f_led", led_out[31:0], 32'h00000000);
	endtask
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 32'h0;
		wdata = 32'h0;
		araddr = 32'h0;
		pat = 80'h5A5A5A5A5A5A5A5A5A5A;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_bus();
		t_led();
		t_slot();
		t_preset();
		t_factory();
		close_out();
	end
endmodule // tb_top
